// File: design/acs_sequencer.sv
// Design decisions made here: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/1ps
// ------------------------------------------------------------
// conversion sequencer with axi4-lite register slave
// ------------------------------------------------------------
module acs_sequencer
(
	input  wire logic        i_clk_sys,
	input  wire logic        i_reset_n,
	// axi4-lite slave
	input  wire logic [7:0]  i_s_axi_awaddr,
	input  wire logic        i_s_axi_awvalid,
	output logic             o_s_axi_awready,
	input  wire logic [31:0] i_s_axi_wdata,
	input  wire logic [3:0]  i_s_axi_wstrb,
	input  wire logic        i_s_axi_wvalid,
	output logic             o_s_axi_wready,
	output logic [1:0]       o_s_axi_bresp,
	output logic             o_s_axi_bvalid,
	input  wire logic        i_s_axi_bready,
	input  wire logic [7:0]  i_s_axi_araddr,
	input  wire logic        i_s_axi_arvalid,
	output logic             o_s_axi_arready,
	output logic [31:0]      o_s_axi_rdata,
	output logic [1:0]       o_s_axi_rresp,
	output logic             o_s_axi_rvalid,
	input  wire logic        i_s_axi_rready,
	// analog side
	input  wire logic [9:0]  i_conv_result,
	input  wire logic        i_low_power,
	output logic             o_conv_start,
	output logic [3:0]       o_channel_select,
	output logic             o_analog_input_enable,
	output logic             o_ref_connect,
	output logic             o_converter_busy_flag,
	output logic             o_conversion_done_irq
);

	// ------------------------------------------------------------
	// shared decode
	// ------------------------------------------------------------
	function automatic logic is_reg(input logic [7:0] addr, input logic [5:0] idx);
		is_reg = (addr[7:2] == idx) && (addr[1:0] == 2'h0);
	endfunction

	function automatic logic is_mapped(input logic [7:0] addr);
		is_mapped = is_reg(addr, acs_pkg::IDX_CTRL_ONE) || is_reg(addr, acs_pkg::IDX_CTRL_TWO)
		         || is_reg(addr, acs_pkg::IDX_RESULT_LOW) || is_reg(addr, acs_pkg::IDX_RESULT_HI);
	endfunction

	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	acs_pkg::acs_state_t state_ff;
	acs_pkg::acs_state_t nxt_state;
	logic        trig_ff;
	logic [1:0]  mode_ff;
	logic        ain_en_ff;
	logic [3:0]  chan_ff;
	logic [2:0]  time_sel_ff;
	logic        done_ff;
	logic        low_read_ff;
	logic [9:0]  result_ff;
	logic        irq_ff;
	logic [7:0]  aw_addr_ff;
	logic        aw_held_ff;
	logic [7:0]  w_data_ff;
	logic        w_lane0_ff;
	logic        w_held_ff;
	logic        bvalid_ff;
	logic [1:0]  bresp_ff;
	logic        rvalid_ff;
	logic [31:0] rdata_ff;
	logic [1:0]  rresp_ff;
	logic        nxt_trig;
	logic [1:0]  nxt_mode;
	logic        nxt_ain_en;
	logic [3:0]  nxt_chan;
	logic        nxt_done;
	logic        nxt_low_read;
	logic [9:0]  nxt_result;

	// ------------------------------------------------------------
	// bus handshakes
	// ------------------------------------------------------------
	wire aw_take  = i_s_axi_awvalid && o_s_axi_awready;
	wire w_take   = i_s_axi_wvalid && o_s_axi_wready;
	wire wr_fire  = aw_held_ff && w_held_ff && !bvalid_ff;
	wire ar_take  = i_s_axi_arvalid && o_s_axi_arready;
	wire wr_lane  = wr_fire && w_lane0_ff;
	wire wr_ctl1  = wr_lane && is_reg(aw_addr_ff, acs_pkg::IDX_CTRL_ONE);
	wire wr_ctl2  = wr_lane && is_reg(aw_addr_ff, acs_pkg::IDX_CTRL_TWO);
	wire rd_low   = ar_take && is_reg(i_s_axi_araddr, acs_pkg::IDX_RESULT_LOW);
	wire rd_high  = ar_take && is_reg(i_s_axi_araddr, acs_pkg::IDX_RESULT_HI);

	assign o_s_axi_awready = !aw_held_ff && !bvalid_ff;
	assign o_s_axi_wready  = !w_held_ff && !bvalid_ff;
	assign o_s_axi_arready = !rvalid_ff;

	// ------------------------------------------------------------
	// sequencing decisions
	// ------------------------------------------------------------
	wire mode_off   = (mode_ff == acs_pkg::MODE_OFF);
	wire clear_all  = i_low_power || mode_off;
	wire mode_ok    = (mode_ff == acs_pkg::MODE_SINGLE) || (mode_ff == acs_pkg::MODE_REPEAT);
	wire start_go   = (state_ff == acs_pkg::ST_IDLE) && trig_ff && mode_ok && !i_low_power;
	wire timer_exp;
	wire conv_end   = (state_ff == acs_pkg::ST_CONV) && timer_exp && !clear_all;
	wire keep_old   = low_read_ff && !rd_high;
	wire store      = conv_end && !keep_old;
	wire restart    = conv_end && (mode_ff == acs_pkg::MODE_REPEAT);
	wire timer_load = start_go || restart;

	// next conversion state
	always_comb
	begin
		nxt_state = state_ff;
		unique case (state_ff)
			acs_pkg::ST_IDLE:
				if (start_go)
					nxt_state = acs_pkg::ST_CONV;
			acs_pkg::ST_CONV:
				if (clear_all)
					nxt_state = acs_pkg::ST_IDLE;
				else if (conv_end && !restart)
					nxt_state = acs_pkg::ST_IDLE;
			default:
				nxt_state = acs_pkg::ST_IDLE;
		endcase
	end

	acs_conv_timer u_timer
	(
		.i_clk_sys (i_clk_sys),
		.i_reset_n (i_reset_n),
		.i_load    (timer_load),
		.i_stop    (clear_all),
		.i_limit   (acs_pkg::conv_cycles(time_sel_ff)),
		.o_expire  (timer_exp)
	);

	// ------------------------------------------------------------
	// control register one
	// ------------------------------------------------------------
	// low power wins over any write; trigger, mode and input enable clear, but the channel survives sleep
	always_comb
	begin
		nxt_trig   = trig_ff;
		nxt_mode   = mode_ff;
		nxt_ain_en = ain_en_ff;
		nxt_chan   = chan_ff;
		if (wr_ctl1)
		begin
			nxt_trig   = w_data_ff[acs_pkg::CTRL1_TRIG_BIT];
			nxt_mode   = w_data_ff[acs_pkg::CTRL1_MODE_HI:acs_pkg::CTRL1_MODE_LO];
			nxt_ain_en = w_data_ff[acs_pkg::CTRL1_AIN_BIT];
			nxt_chan   = w_data_ff[acs_pkg::CTRL1_CHAN_HI:0];
		end
		else if (state_ff == acs_pkg::ST_IDLE)
			nxt_trig = 1'b0;
		if (i_low_power)
		begin
			nxt_trig   = 1'b0;
			nxt_mode   = acs_pkg::MODE_OFF;
			nxt_ain_en = 1'b0;
		end
	end

	// ------------------------------------------------------------
	// done flag, read tracking, results
	// ------------------------------------------------------------
	// set beats clear: a completion beats a same-cycle read, but sets no flag while a low-byte read is pending
	always_comb
	begin
		nxt_done     = done_ff;
		nxt_low_read = low_read_ff;
		nxt_result   = result_ff;
		if (clear_all)
		begin
			nxt_done     = 1'b0;
			nxt_low_read = 1'b0;
			nxt_result   = acs_pkg::RST_RESULT;
		end
		else
		begin
			if (store)
			begin
				nxt_done   = 1'b1;
				nxt_result = i_conv_result;
			end
			else if (rd_high || start_go)
				nxt_done = 1'b0;
			if (rd_high)
				nxt_low_read = 1'b0;
			else if (rd_low)
				nxt_low_read = 1'b1;
		end
	end

	// core registers
	always_ff @(posedge i_clk_sys)
	begin
		if (!i_reset_n)
		begin
			state_ff    <= acs_pkg::ST_IDLE;
			trig_ff     <= 1'b0;
			mode_ff     <= acs_pkg::MODE_OFF;
			ain_en_ff   <= 1'b0;
			chan_ff     <= acs_pkg::RST_CHAN;
			time_sel_ff <= acs_pkg::RST_TIME;
			done_ff     <= 1'b0;
			low_read_ff <= 1'b0;
			result_ff   <= acs_pkg::RST_RESULT;
			irq_ff      <= 1'b0;
		end
		else
		begin
			state_ff    <= nxt_state;
			trig_ff     <= nxt_trig;
			mode_ff     <= nxt_mode;
			ain_en_ff   <= nxt_ain_en;
			chan_ff     <= nxt_chan;
			time_sel_ff <= wr_ctl2 ? w_data_ff[acs_pkg::CTRL2_TIME_HI:0] : time_sel_ff;
			done_ff     <= nxt_done;
			low_read_ff <= nxt_low_read;
			result_ff   <= nxt_result;
			irq_ff      <= store;
		end
	end

	// ------------------------------------------------------------
	// write channel
	// ------------------------------------------------------------
	// address and data latch independently, so either may come first
	always_ff @(posedge i_clk_sys)
	begin
		if (!i_reset_n)
		begin
			aw_addr_ff <= 8'h00;
			aw_held_ff <= 1'b0;
			w_data_ff  <= 8'h00;
			w_lane0_ff <= 1'b0;
			w_held_ff  <= 1'b0;
			bvalid_ff  <= 1'b0;
			bresp_ff   <= acs_pkg::RESP_OKAY;
		end
		else
		begin
			if (aw_take)
			begin
				aw_addr_ff <= i_s_axi_awaddr;
				aw_held_ff <= 1'b1;
			end
			else if (wr_fire)
				aw_held_ff <= 1'b0;
			if (w_take)
			begin
				w_data_ff  <= i_s_axi_wdata[7:0];
				w_lane0_ff <= i_s_axi_wstrb[0];
				w_held_ff  <= 1'b1;
			end
			else if (wr_fire)
				w_held_ff <= 1'b0;
			if (wr_fire)
			begin
				bvalid_ff <= 1'b1;
				bresp_ff  <= is_mapped(aw_addr_ff) ? acs_pkg::RESP_OKAY : acs_pkg::RESP_SLVERR;
			end
			else if (i_s_axi_bready)
				bvalid_ff <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// read channel
	// ------------------------------------------------------------
	wire [7:0] ctl1_view = {trig_ff, mode_ff, ain_en_ff, chan_ff};
	wire [7:0] ctl2_view = {done_ff, o_converter_busy_flag, 3'h0, time_sel_ff};
	wire [7:0] high_view = {6'h00, result_ff[9:8]};
	wire [7:0] rd_byte   =
		is_reg(i_s_axi_araddr, acs_pkg::IDX_CTRL_ONE)   ? ctl1_view :
		is_reg(i_s_axi_araddr, acs_pkg::IDX_CTRL_TWO)   ? ctl2_view :
		is_reg(i_s_axi_araddr, acs_pkg::IDX_RESULT_LOW) ? result_ff[7:0] :
		is_reg(i_s_axi_araddr, acs_pkg::IDX_RESULT_HI)  ? high_view : 8'h00;

	// data are captured at the address handshake, side effects act then too
	always_ff @(posedge i_clk_sys)
	begin
		if (!i_reset_n)
		begin
			rvalid_ff <= 1'b0;
			rdata_ff  <= 32'h00000000;
			rresp_ff  <= acs_pkg::RESP_OKAY;
		end
		else if (ar_take)
		begin
			rvalid_ff <= 1'b1;
			rdata_ff  <= {24'h000000, rd_byte};
			rresp_ff  <= is_mapped(i_s_axi_araddr) ? acs_pkg::RESP_OKAY : acs_pkg::RESP_SLVERR;
		end
		else if (i_s_axi_rready)
			rvalid_ff <= 1'b0;
	end

	// ------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------
	// reference stays open in sleep; software must reprogram on wake
	assign o_ref_connect         = ain_en_ff && !i_low_power;
	assign o_conv_start          = timer_load;
	assign o_channel_select      = chan_ff;
	assign o_analog_input_enable = ain_en_ff;
	assign o_converter_busy_flag = (state_ff == acs_pkg::ST_CONV);
	assign o_conversion_done_irq = irq_ff;
	assign o_s_axi_bvalid        = bvalid_ff;
	assign o_s_axi_bresp         = bresp_ff;
	assign o_s_axi_rvalid        = rvalid_ff;
	assign o_s_axi_rdata         = rdata_ff;
	assign o_s_axi_rresp         = rresp_ff;

endmodule

// File: design/acs_pkg.sv
package acs_pkg;

	// ------------------------------------------------------------
	// register indices (byte address is four times the index)
	// ------------------------------------------------------------
	localparam logic [5:0] IDX_CTRL_ONE   = 6'h34;
	localparam logic [5:0] IDX_CTRL_TWO   = 6'h35;
	localparam logic [5:0] IDX_RESULT_LOW = 6'h36;
	localparam logic [5:0] IDX_RESULT_HI  = 6'h37;

	// ------------------------------------------------------------
	// field positions
	// ------------------------------------------------------------
	localparam int CTRL1_TRIG_BIT  = 7;
	localparam int CTRL1_MODE_HI   = 6;
	localparam int CTRL1_MODE_LO   = 5;
	localparam int CTRL1_AIN_BIT   = 4;
	localparam int CTRL1_CHAN_HI   = 3;
	localparam int CTRL2_DONE_BIT  = 7;
	localparam int CTRL2_BUSY_BIT  = 6;
	localparam int CTRL2_TIME_HI   = 2;

	// ------------------------------------------------------------
	// modes, reset values, bus answers
	// ------------------------------------------------------------
	localparam logic [1:0] MODE_OFF    = 2'h0;
	localparam logic [1:0] MODE_SINGLE = 2'h1;
	localparam logic [1:0] MODE_REPEAT = 2'h3;
	localparam logic [3:0] RST_CHAN    = 4'h0;
	localparam logic [2:0] RST_TIME    = 3'h0;
	localparam logic [9:0] RST_RESULT  = 10'h000;
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// ------------------------------------------------------------
	// conversion times in clock periods
	// ------------------------------------------------------------
	localparam logic [10:0] CYC_T0 = 11'd39;
	localparam logic [10:0] CYC_T1 = 11'd78;
	localparam logic [10:0] CYC_T2 = 11'd156;
	localparam logic [10:0] CYC_T3 = 11'd312;
	localparam logic [10:0] CYC_T4 = 11'd624;
	localparam logic [10:0] CYC_T5 = 11'd1248;

	// reserved codes fall back to the slowest, safest setting
	function automatic logic [10:0] conv_cycles(input logic [2:0] code);
		unique case (code)
			3'h0:    conv_cycles = CYC_T0;
			3'h1:    conv_cycles = CYC_T1;
			3'h2:    conv_cycles = CYC_T2;
			3'h3:    conv_cycles = CYC_T3;
			3'h4:    conv_cycles = CYC_T4;
			default: conv_cycles = CYC_T5;
		endcase
	endfunction

	typedef enum logic [1:0] {
		ST_IDLE = 2'b01,
		ST_CONV = 2'b10
	} acs_state_t;

endpackage

// File: design/acs_conv_timer.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// conversion period counter
// ------------------------------------------------------------
module acs_conv_timer
(
	input  wire logic        i_clk_sys,
	input  wire logic        i_reset_n,
	input  wire logic        i_load,
	input  wire logic        i_stop,
	input  wire logic [10:0] i_limit,
	output logic             o_expire
);

	logic [10:0] count_ff;
	logic        run_ff;
	logic [10:0] nxt_count;
	logic        nxt_run;
	wire         last_cyc = run_ff && (count_ff == i_limit - 11'd1);

	// load restarts the count; the last cycle of the period flags expiry
	always_comb
	begin
		nxt_count = count_ff;
		nxt_run   = run_ff;
		if (i_stop)
		begin
			nxt_count = 11'd0;
			nxt_run   = 1'b0;
		end
		else if (i_load)
		begin
			nxt_count = 11'd0;
			nxt_run   = 1'b1;
		end
		else if (last_cyc)
		begin
			nxt_count = 11'd0;
			nxt_run   = 1'b0;
		end
		else if (run_ff)
			nxt_count = count_ff + 11'd1;
	end

	always_ff @(posedge i_clk_sys)
	begin
		if (!i_reset_n)
		begin
			count_ff <= 11'd0;
			run_ff   <= 1'b0;
		end
		else
		begin
			count_ff <= nxt_count;
			run_ff   <= nxt_run;
		end
	end

	// load is left out on purpose: a repeat restart is itself driven by expiry
	assign o_expire = last_cyc && !i_stop;

endmodule

// File: verif/acs_seq_props.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// port checker for the conversion sequencer
// ------------------------------------------------------------
module acs_seq_props
(
	input wire logic	i_clk_sys,
	input wire logic	i_reset_n,
	input wire logic	i_low_power,
	input wire logic	i_s_axi_bready,
	input wire logic	i_s_axi_rready,
	input wire logic	o_s_axi_bvalid,
	input wire logic	o_s_axi_rvalid,
	input wire logic	o_conv_start,
	input wire logic	o_ref_connect,
	input wire logic	o_analog_input_enable,
	input wire logic	o_converter_busy_flag,
	input wire logic	o_conversion_done_irq
);
	default clocking cb @(posedge i_clk_sys);
	endclocking
	default disable iff (!i_reset_n);

	// start and completion timing
	a_start_busy: assert property (o_conv_start |=> o_converter_busy_flag)
		else $error("busy not set after start");
	a_irq_pulse: assert property (o_conversion_done_irq |=> !o_conversion_done_irq)
		else $error("done irq longer than one cycle");
	a_irq_cause: assert property (o_conversion_done_irq |-> $past(o_converter_busy_flag))
		else $error("done irq without a conversion");
	// shortest time code still needs 39 cycles, so no irq soon after a fresh start
	a_first_gap: assert property ($rose(o_converter_busy_flag) |-> !o_conversion_done_irq [*8])
		else $error("irq too soon after start");
	// low-power entry
	a_lp_clear: assert property (i_low_power |=> !o_converter_busy_flag && !o_analog_input_enable)
		else $error("state kept in low power");
	a_lp_ref: assert property (i_low_power |-> !o_ref_connect)
		else $error("reference connected in low power");
	a_lp_noirq: assert property (i_low_power [*2] |-> !o_conversion_done_irq)
		else $error("irq during low power");
	a_lp_nostart: assert property ($past(i_low_power) && i_low_power |-> !o_conv_start)
		else $error("start during low power");
	// bus answers stand until taken
	a_bresp_hold: assert property (o_s_axi_bvalid && !i_s_axi_bready |=> o_s_axi_bvalid)
		else $error("bvalid dropped early");
	a_rdata_hold: assert property (o_s_axi_rvalid && !i_s_axi_rready |=> o_s_axi_rvalid)
		else $error("rvalid dropped early");
endmodule

bind acs_sequencer acs_seq_props u_props
(
	.i_clk_sys(i_clk_sys), .i_reset_n(i_reset_n), .i_low_power(i_low_power),
	.i_s_axi_bready(i_s_axi_bready), .i_s_axi_rready(i_s_axi_rready),
	.o_s_axi_bvalid(o_s_axi_bvalid), .o_s_axi_rvalid(o_s_axi_rvalid),
	.o_conv_start(o_conv_start), .o_ref_connect(o_ref_connect),
	.o_analog_input_enable(o_analog_input_enable),
	.o_converter_busy_flag(o_converter_busy_flag),
	.o_conversion_done_irq(o_conversion_done_irq)
);

// File: verif/acs_analog_model.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// analog converter stand-in: new sample per start
// ------------------------------------------------------------
module acs_analog_model
(
	input wire logic	i_clk_sys,
	input wire logic	i_start,
	input wire logic	i_busy,
	input wire logic	i_ref_on,
	output logic [9:0]	o_result,
	output logic [9:0]	o_cur,
	output logic [9:0]	o_prev
);
	logic [9:0] cur_ff = 10'h2a5;
	logic [9:0] prev_ff = 10'h000;

	// step is above 8'hff so high bits move between samples
	always_ff @(posedge i_clk_sys)
	begin
		if (i_start)
		begin
			prev_ff <= cur_ff;
			cur_ff <= cur_ff + 10'h137;
		end
	end
	// idle or unpowered: inverted value, never the real sample
	assign o_result = (i_busy && i_ref_on) ? cur_ff : ~cur_ff;
	assign o_cur = cur_ff;
	assign o_prev = prev_ff;
endmodule

// File: verif/adc_conversion_sequencer_tb_top.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// bench for the conversion sequencer
// ------------------------------------------------------------
module adc_conversion_sequencer_tb_top;
	localparam logic [7:0] A1 = {acs_pkg::IDX_CTRL_ONE, 2'h0};
	localparam logic [7:0] A2 = {acs_pkg::IDX_CTRL_TWO, 2'h0};
	localparam logic [7:0] AL = {acs_pkg::IDX_RESULT_LOW, 2'h0};
	localparam logic [7:0] AH = {acs_pkg::IDX_RESULT_HI, 2'h0};
	logic clk = 1'b0, rst_n = 1'b0, lp = 1'b0, busy_q = 1'b0;
	logic [7:0] awaddr = 8'h00, araddr = 8'h00;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic [31:0] wdata = 32'h0, rdata;
	logic [3:0] wstrb = 4'hf, chan;
	logic awready, wready, bvalid, arready, rvalid, start, aie, refc, busy, irq;
	logic [1:0] bresp, rresp, rsp;
	logic [9:0] ares, cur, prv;
	int fail_count = 0, cmp_count = 0, start_cnt = 0, irq_cnt = 0;
	int bcnt = 0, blen = 0, fall_cnt = 0, tick = 0;
	int tab[7] = '{39, 78, 156, 312, 624, 1248, 1248};

	acs_sequencer DUT
	(
		.i_clk_sys(clk), .i_reset_n(rst_n),
		.i_s_axi_awaddr(awaddr), .i_s_axi_awvalid(awvalid), .o_s_axi_awready(awready),
		.i_s_axi_wdata(wdata), .i_s_axi_wstrb(wstrb), .i_s_axi_wvalid(wvalid),
		.o_s_axi_wready(wready), .o_s_axi_bresp(bresp), .o_s_axi_bvalid(bvalid),
		.i_s_axi_bready(bready), .i_s_axi_araddr(araddr), .i_s_axi_arvalid(arvalid),
		.o_s_axi_arready(arready), .o_s_axi_rdata(rdata), .o_s_axi_rresp(rresp),
		.o_s_axi_rvalid(rvalid), .i_s_axi_rready(rready),
		.i_conv_result(ares), .i_low_power(lp), .o_conv_start(start),
		.o_channel_select(chan), .o_analog_input_enable(aie), .o_ref_connect(refc),
		.o_converter_busy_flag(busy), .o_conversion_done_irq(irq)
	);
	acs_analog_model u_analog
	(
		.i_clk_sys(clk), .i_start(start), .i_busy(busy), .i_ref_on(refc),
		.o_result(ares), .o_cur(cur), .o_prev(prv)
	);

	always #2.5 clk = ~clk;

	// event counters sampled mid-cycle, away from the launching edge
	always @(negedge clk)
	begin
		if (start)
			start_cnt++;
		if (irq)
			irq_cnt++;
		if (busy_q && !busy)
			fall_cnt++;
		if (busy)
			bcnt++;
		else
		begin
			if (bcnt != 0)
				blen = bcnt;
			bcnt = 0;
		end
		busy_q = busy;
	end

	// hang guard
	always @(posedge clk)
	begin
		tick++;
		if (tick == 20000)
		begin
			fail_count++;
			$display("[FAIL] %0t timeout", $time);
			wrap_up;
		end
	end

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp)
		begin
			fail_count++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
	endtask

	// each channel released at the edge where it is taken
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		logic aw, w, b;
		awaddr <= a;
		wdata <= {24'h000000, d};
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		b = 1'b0;
		while (!b)
		begin
			@(negedge clk);
			aw = awvalid && awready;
			w = wvalid && wready;
			b = bvalid && bready;
			rsp = bresp;
			@(posedge clk);
			if (aw)
				awvalid <= 1'b0;
			if (w)
				wvalid <= 1'b0;
		end
		bready <= 1'b0;
		@(posedge clk);
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		logic ar, r;
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		r = 1'b0;
		while (!r)
		begin
			@(negedge clk);
			ar = arvalid && arready;
			r = rvalid && rready;
			d = rdata;
			rsp = rresp;
			@(posedge clk);
			if (ar)
				arvalid <= 1'b0;
		end
		rready <= 1'b0;
		@(posedge clk);
	endtask

	task automatic wirq(input int n);
		int t;
		t = irq_cnt + n;
		while (irq_cnt < t) @(posedge clk);
	endtask

	// configure first, trigger in a separate write
	task automatic go(input logic [7:0] m);
		wr(A1, m);
		wr(A1, m | 8'h80);
	endtask

	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	task automatic t_regs;
		logic [31:0] d;
		rd(A2, d); chk(d, 32'h0);
		chk(rsp, acs_pkg::RESP_OKAY);
		rd(AH, d); chk(d, 32'h0);
		rd(8'h00, d); chk(d, 32'h0);
		chk(rsp, acs_pkg::RESP_SLVERR);
		wr(8'h00, 8'hff);
		chk(rsp, acs_pkg::RESP_SLVERR);
		wr(A2, 8'h00);
		chk(rsp, acs_pkg::RESP_OKAY);
	endtask

	task automatic t_single;
		for (int k = 0; k < 7; k++)
		begin
			logic [31:0] d;
			int s0, i0;
			wr(A2, 8'(k));
			s0 = start_cnt;
			i0 = irq_cnt;
			go(8'h33);
			chk(chan, 4'h3);
			rd(A1, d); chk(d & 32'h80, 32'h0);
			wirq(1);
			rd(A2, d); chk(d & 32'hc7, 32'(32'h80 | k));
			rd(AL, d); chk(d, cur[7:0]);
			rd(AH, d); chk(d, cur[9:8]);
			rd(A2, d); chk(d & 32'h80, 32'h0);
			chk(blen, tab[k]);
			chk(start_cnt - s0, 1);
			chk(irq_cnt - i0, 1);
		end
	endtask

	task automatic t_restart;
		logic [31:0] d;
		logic [9:0] o;
		wr(A2, 8'h00);
		go(8'h33);
		wirq(1);
		o = cur;
		wr(A1, 8'hb3);
		rd(A2, d); chk(d & 32'hc0, 32'h40);
		rd(AL, d); chk(d, o[7:0]);
		rd(AH, d); chk(d, o[9:8]);
		wirq(1);
		rd(AL, d); chk(d, cur[7:0]);
		rd(AH, d); chk(d, cur[9:8]);
	endtask

	task automatic t_repeat;
		logic [31:0] d;
		logic [9:0] e;
		int s0, f0, i0;
		s0 = start_cnt;
		f0 = fall_cnt;
		go(8'h73);
		wirq(1);
		rd(AL, d);
		rd(AH, d);
		wirq(2);
		chk(start_cnt - s0, 4);
		chk(fall_cnt - f0, 0);
		wirq(1);
		e = prv;
		rd(AL, d); chk(d, e[7:0]);
		i0 = irq_cnt;
		s0 = start_cnt;
		while (start_cnt == s0) @(posedge clk);
		cyc(3);
		chk(irq_cnt - i0, 0);
		rd(AH, d); chk(d, e[9:8]);
		wr(A1, 8'h13);
		rd(A2, d); chk(d & 32'hc0, 32'h0);
		rd(AL, d); chk(d, 32'h0);
		rd(AH, d); chk(d, 32'h0);
	endtask

	task automatic t_abort;
		int i0;
		go(8'h33);
		cyc(10);
		i0 = irq_cnt;
		wr(A1, 8'h13);
		chk(busy, 1'b0);
		cyc(60);
		chk(irq_cnt - i0, 0);
	endtask

	task automatic t_lowpower;
		logic [31:0] d;
		int s0;
		go(8'h73);
		cyc(10);
		chk(refc, 1'b1);
		lp <= 1'b1;
		// first sleep cycle: enable still set, so only the sleep gate opens the reference
		@(negedge clk);
		chk(refc, 1'b0);
		cyc(3);
		chk(refc, 1'b0);
		lp <= 1'b0;
		cyc(1);
		s0 = start_cnt;
		rd(A1, d); chk(d & 32'hf0, 32'h0);
		rd(A2, d); chk(d & 32'hc0, 32'h0);
		cyc(60);
		chk(start_cnt - s0, 0);
		chk(aie, 1'b0);
	endtask

	// ------------------------------------------------------------
	// run and verdict
	// ------------------------------------------------------------
	task wrap_up;
		$display("comparisons %0d mismatches %0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	initial
	begin
		repeat (16) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		t_regs;
		t_single;
		t_restart;
		t_repeat;
		t_abort;
		t_lowpower;
		wrap_up;
	end
endmodule
